// File: shared/fpsc_pkg.sv
// Purpose: constants and types for the front panel step control block
// Assumes: 50 MHz system clock, APB register access
// Notes:   lamp outputs are active high (1 = lit)
package fpsc_pkg;
  // bus widths
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  // panel port number shared by input switches and output lamps
  localparam logic [7:0] PANEL_PORT = 8'hFF;
  // switch settle time and derived cycles
  localparam int CLK_HZ      = 50_000_000;
  localparam int DEB_TIME_MS = 5;
  localparam int DEB_CYC     = CLK_HZ / 1000 * DEB_TIME_MS;
  // register byte offsets
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_LAMP   = 8'h08;
  localparam logic [7:0] REG_ADDR   = 8'h0C;
  // control bit positions (write one to act)
  localparam int CTRL_RUN  = 0;
  localparam int CTRL_STOP = 1;
  localparam int CTRL_STEP = 2;
  // status bit positions
  localparam int ST_RUN  = 0;
  localparam int ST_WAIT = 1;
  localparam int ST_SPND = 2;
  localparam int ST_STEP = 3;
  // reset values
  localparam logic [7:0] PROG_LAMP_RST = 8'h00;
  localparam logic       RUN_RST       = 1'b0;
  // machine cycle status flags from the processor
  typedef struct packed {
    logic memory_read_flag;
    logic opcode_fetch_flag;
    logic input_cycle_flag;
    logic output_cycle_flag;
  } fpsc_cyc_t;
  // status lamp group
  typedef struct packed {
    logic memory_read_flag;
    logic opcode_fetch_flag;
    logic input_cycle_flag;
    logic output_cycle_flag;
    logic write_out_inactive_flag;
  } fpsc_lamp_t;
  // panel switch group index
  typedef enum logic [1:0] {
    SW_RUN  = 2'h0,
    SW_STOP = 2'h1,
    SW_STEP = 2'h2
  } fpsc_sw_t;
endpackage

// File: hw/fpsc_top.sv
// Purpose: front panel run/stop/step control, cycle display and panel I/O port
// Assumes: processor holds a cycle while I_CYC_VALID is high until O_CPU_READY
// Notes:   switch inputs are synchronous; debounce time is a parameter
//
// Local design decisions: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps

// debounce one switch and emit a single-clock pulse on each settled press
module fpsc_debounce #(
  parameter int CYC = 16
) (
  input  wire logic i_clk,
  input  wire logic i_srst,
  input  wire logic i_sw,
  output logic      o_pulse
);
  logic [31:0] cnt_q;
  logic        stable_q;
  logic        raw_q;

  // restart the settle count on every change of the raw level
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      raw_q    <= 1'b0;
      stable_q <= 1'b0;
      cnt_q    <= 32'h0;
      o_pulse  <= 1'b0;
    end else begin
      raw_q   <= i_sw;
      o_pulse <= 1'b0;
      if (raw_q != stable_q) begin
        if (cnt_q >= 32'(CYC - 1)) begin
          stable_q <= raw_q;
          cnt_q    <= 32'h0;
          o_pulse  <= raw_q; // only the settled closing counts
        end else begin
          cnt_q <= cnt_q + 32'h1;
        end
      end else begin
        cnt_q <= 32'h0;
      end
    end
  end
endmodule

module fpsc_top #(
  parameter int DEB_CYC = fpsc_pkg::DEB_CYC
) (
  input  wire logic                       I_SYS_CLK,
  input  wire logic                       I_SRST,
  // processor cycle side
  input  wire logic                       i_cyc_valid,
  input  wire fpsc_pkg::fpsc_cyc_t        i_cyc_stat,
  input  wire logic [15:0]                i_cpu_addr,
  input  wire logic [7:0]                 i_cpu_dout,
  input  wire logic [7:0]                 i_bus_data,
  input  wire logic                       i_cpu_wr_n,
  output logic                            o_cpu_ready,
  output logic [7:0]                      o_port_data,
  output logic                            o_port_sel,
  // operator switches
  input  wire logic                       i_run_sw,
  input  wire logic                       i_stop_sw,
  input  wire logic                       i_step_up_sw,
  input  wire logic                       i_step_dn_sw,
  input  wire logic [7:0]                 i_data_sw,
  // lamps
  output logic [15:0]                     o_addr_lamp,
  output logic [7:0]                      o_data_lamp,
  output fpsc_pkg::fpsc_lamp_t            o_stat_lamp,
  output logic [7:0]                      o_prog_lamp,
  output logic                            o_run_lamp,
  output logic                            o_wait_lamp,
  // APB slave
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [7:0]                 paddr,
  input  wire logic [31:0]                pwdata,
  output logic [31:0]                     prdata,
  output logic                            pready,
  output logic                            pslverr
);
  logic [2:0] sw_raw;
  logic [2:0] sw_pulse;
  logic       run_q;
  logic       stop_pend_q;
  logic       step_q;
  logic       done;
  logic       io_cyc;
  logic       panel_hit;
  logic       hold_fetch;
  logic       sw_run;
  logic       sw_stop;
  logic       sw_step;
  logic       apb_wr;
  logic       apb_rd;
  logic [31:0] rd_d;
  logic [31:0] rdata_q;
  logic        err_q;

  // either direction of the step lever counts as one actuation
  assign sw_raw[fpsc_pkg::SW_RUN]  = i_run_sw;
  assign sw_raw[fpsc_pkg::SW_STOP] = i_stop_sw;
  assign sw_raw[fpsc_pkg::SW_STEP] = i_step_up_sw | i_step_dn_sw;

  // one debouncer each for the run, stop and step lever switches
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_deb
      fpsc_debounce #(.CYC(DEB_CYC)) u_deb (
        .i_clk   (I_SYS_CLK),
        .i_srst  (I_SRST),
        .i_sw    (sw_raw[g]),
        .o_pulse (sw_pulse[g])
      );
    end
  endgenerate

  // write strobes of the APB control register, and the setup-phase read strobe
  assign apb_wr = psel & penable & pwrite & (paddr == fpsc_pkg::REG_CTRL);
  assign apb_rd = psel & ~penable & ~pwrite;
  assign sw_run  = sw_pulse[fpsc_pkg::SW_RUN]
                 | (apb_wr & pwdata[fpsc_pkg::CTRL_RUN]);
  assign sw_stop = sw_pulse[fpsc_pkg::SW_STOP]
                 | (apb_wr & pwdata[fpsc_pkg::CTRL_STOP]);
  assign sw_step = sw_pulse[fpsc_pkg::SW_STEP]
                 | (apb_wr & pwdata[fpsc_pkg::CTRL_STEP]);

  // cycle decode
  assign io_cyc    = i_cyc_stat.input_cycle_flag | i_cyc_stat.output_cycle_flag;
  assign panel_hit = i_cpu_addr[7:0] == fpsc_pkg::PANEL_PORT;
  // a pending stop catches the next fetch before it completes
  assign hold_fetch = stop_pend_q & i_cyc_stat.opcode_fetch_flag;

  // release the processor: free when running except a fetch held by a pending stop, one cycle per step when stopped
  always_comb begin
    if (run_q) begin
      o_cpu_ready = ~hold_fetch;
    end else begin
      o_cpu_ready = step_q;
    end
  end
  assign done = i_cyc_valid & o_cpu_ready;

  // run/stop flip-flop; a fetch caught by a pending stop drops to stop
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SRST) begin
      run_q       <= fpsc_pkg::RUN_RST;
      stop_pend_q <= 1'b0;
    end else if (sw_run) begin
      run_q       <= 1'b1; // resume from where it waits
      stop_pend_q <= 1'b0;
    end else if (run_q && hold_fetch && i_cyc_valid) begin
      run_q       <= 1'b0; // halted in the fetch wait
      stop_pend_q <= 1'b0;
    end else if (sw_stop && run_q) begin
      stop_pend_q <= 1'b1;
    end
  end

  // single step grant: set by a pulse, spent by one completed cycle
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SRST) begin
      step_q <= 1'b0;
    end else if (sw_step && !run_q) begin
      step_q <= 1'b1; // a new pulse wins over the spend
    end else if (done || run_q) begin
      step_q <= 1'b0; // exactly one cycle per step
    end
  end

  // programmed input port answers the panel port number
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SRST) begin
      o_port_data <= 8'h00;
      o_port_sel  <= 1'b0;
    end else begin
      o_port_data <= i_data_sw;
      o_port_sel  <= i_cyc_valid & i_cyc_stat.input_cycle_flag & panel_hit;
    end
  end

  // programmed output latch: inverted byte, loaded as the write completes
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SRST) begin
      o_prog_lamp <= fpsc_pkg::PROG_LAMP_RST;
    end else if (done && i_cyc_stat.output_cycle_flag && panel_hit) begin
      o_prog_lamp <= ~i_cpu_dout; // dark for a one bit
    end
  end

  // address lamps: binary address, or port number on both bytes for I/O
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SRST) begin
      o_addr_lamp <= 16'h0000;
    end else if (io_cyc) begin
      o_addr_lamp <= {i_cpu_addr[7:0], i_cpu_addr[7:0]};
    end else begin
      o_addr_lamp <= i_cpu_addr;
    end
  end

  // data lamps follow whoever drives the data bus this cycle
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SRST) begin
      o_data_lamp <= 8'h00;
    end else if (i_cyc_stat.output_cycle_flag || !i_cpu_wr_n) begin
      o_data_lamp <= i_cpu_dout;
    end else if (i_cyc_stat.input_cycle_flag && panel_hit) begin
      o_data_lamp <= i_data_sw;
    end else begin
      o_data_lamp <= i_bus_data;
    end
  end

  // status lamps mirror the cycle flags and the write strobe
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SRST) begin
      o_stat_lamp <= '0;
    end else begin
      o_stat_lamp.memory_read_flag  <= i_cyc_stat.memory_read_flag;
      o_stat_lamp.opcode_fetch_flag <= i_cyc_stat.opcode_fetch_flag;
      o_stat_lamp.input_cycle_flag  <= i_cyc_stat.input_cycle_flag;
      o_stat_lamp.output_cycle_flag <= i_cyc_stat.output_cycle_flag;
      o_stat_lamp.write_out_inactive_flag <= i_cpu_wr_n;
    end
  end

  // run and wait lamps
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SRST) begin
      o_run_lamp  <= 1'b0;
      o_wait_lamp <= 1'b0;
    end else begin
      o_run_lamp  <= run_q;
      o_wait_lamp <= i_cyc_valid & ~o_cpu_ready;
    end
  end

  // register read mux
  always_comb begin
    rd_d = 32'h0;
    unique case (paddr)
      fpsc_pkg::REG_CTRL: rd_d = 32'h0;
      fpsc_pkg::REG_STATUS: begin
        rd_d[fpsc_pkg::ST_RUN]  = run_q;
        rd_d[fpsc_pkg::ST_WAIT] = o_wait_lamp;
        rd_d[fpsc_pkg::ST_SPND] = stop_pend_q;
        rd_d[fpsc_pkg::ST_STEP] = step_q;
      end
      fpsc_pkg::REG_LAMP: rd_d = {16'h0, i_data_sw, o_prog_lamp};
      fpsc_pkg::REG_ADDR: rd_d = {16'h0, o_addr_lamp};
      default: rd_d = 32'h0;
    endcase
  end

  // APB: read data and error captured in the setup cycle
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SRST) begin
      rdata_q <= 32'h0;
      err_q   <= 1'b0;
    end else if (psel && !penable) begin
      rdata_q <= apb_rd ? rd_d : 32'h0;
      err_q   <= (paddr != fpsc_pkg::REG_CTRL) && (paddr != fpsc_pkg::REG_STATUS)
              && (paddr != fpsc_pkg::REG_LAMP) && (paddr != fpsc_pkg::REG_ADDR);
    end
  end
  // zero-wait slave
  assign pready  = 1'b1;
  assign prdata  = (psel & penable) ? rdata_q : 32'h0;
  assign pslverr = psel & penable & err_q;

  // checks
  a_stop_holds: assert property (@(posedge I_SYS_CLK) disable iff (I_SRST)
    !run_q && !step_q |-> !o_cpu_ready)
    else $error("cycle released while stopped without step");
  a_step_once: assert property (@(posedge I_SYS_CLK) disable iff (I_SRST)
    !run_q && done && !sw_step |=> !step_q)
    else $error("step grant outlived one cycle");
  a_step_grant: assert property (@(posedge I_SYS_CLK) disable iff (I_SRST)
    sw_pulse[fpsc_pkg::SW_STEP] && !run_q |=> step_q)
    else $error("step pulse gave no grant");
  a_run_free: assert property (@(posedge I_SYS_CLK) disable iff (I_SRST)
    run_q && !stop_pend_q |-> o_cpu_ready)
    else $error("running processor held");
  a_stop_fetch: assert property (@(posedge I_SYS_CLK) disable iff (I_SRST)
    run_q && stop_pend_q && i_cyc_valid && i_cyc_stat.opcode_fetch_flag && !sw_run
    |-> !o_cpu_ready ##1 !run_q)
    else $error("pending stop missed the fetch");
  a_lamp_inv: assert property (@(posedge I_SYS_CLK) disable iff (I_SRST)
    done && i_cyc_stat.output_cycle_flag && panel_hit
    |=> o_prog_lamp == ~$past(i_cpu_dout))
    else $error("output lamps not inverted byte");
  a_lamp_port: assert property (@(posedge I_SYS_CLK) disable iff (I_SRST)
    !(done && i_cyc_stat.output_cycle_flag && panel_hit)
    |=> $stable(o_prog_lamp))
    else $error("output lamps changed without panel write");
  a_lamp_done: assert property (@(posedge I_SYS_CLK) disable iff (I_SRST)
    i_cyc_valid && !o_cpu_ready |=> $stable(o_prog_lamp))
    else $error("lamps changed before write completed");
  a_io_addr: assert property (@(posedge I_SYS_CLK) disable iff (I_SRST)
    io_cyc |=> o_addr_lamp[15:8] == o_addr_lamp[7:0])
    else $error("port number not on both bytes");
  a_mem_addr: assert property (@(posedge I_SYS_CLK) disable iff (I_SRST)
    !io_cyc |=> o_addr_lamp == $past(i_cpu_addr))
    else $error("address lamps wrong");
  a_wo_lamp: assert property (@(posedge I_SYS_CLK) disable iff (I_SRST)
    !i_cpu_wr_n |=> !o_stat_lamp.write_out_inactive_flag)
    else $error("write lamp lit during strobe");
  a_fetch_lamp: assert property (@(posedge I_SYS_CLK) disable iff (I_SRST)
    i_cyc_stat.opcode_fetch_flag && i_cyc_stat.memory_read_flag && i_cpu_wr_n
    |=> o_stat_lamp.opcode_fetch_flag && o_stat_lamp.memory_read_flag
        && o_stat_lamp.write_out_inactive_flag)
    else $error("fetch status lamps wrong");
  a_operand_lamp: assert property (@(posedge I_SYS_CLK) disable iff (I_SRST)
    !i_cyc_stat.opcode_fetch_flag && i_cyc_stat.memory_read_flag
    |=> !o_stat_lamp.opcode_fetch_flag && o_stat_lamp.memory_read_flag)
    else $error("operand status lamps wrong");
  a_out_lamp: assert property (@(posedge I_SYS_CLK) disable iff (I_SRST)
    i_cyc_stat.output_cycle_flag && !i_cyc_stat.memory_read_flag
    |=> o_stat_lamp.output_cycle_flag && !o_stat_lamp.memory_read_flag
        && o_data_lamp == $past(i_cpu_dout))
    else $error("output cycle lamps wrong");
  a_in_port: assert property (@(posedge I_SYS_CLK) disable iff (I_SRST)
    o_port_sel |-> $past(panel_hit) && o_port_data == $past(i_data_sw))
    else $error("input port answered wrong");
  a_deb_pulse: assert property (@(posedge I_SYS_CLK) disable iff (I_SRST)
    sw_pulse[fpsc_pkg::SW_STEP] |=> !sw_pulse[fpsc_pkg::SW_STEP])
    else $error("step pulse longer than one clock");
  // the wait lamp must show every held cycle, or a stopped panel looks hung
  a_wait_show: assert property (@(posedge I_SYS_CLK) disable iff (I_SRST)
    i_cyc_valid && !o_cpu_ready |=> o_wait_lamp)
    else $error("wait lamp dark while cycle held");

  c_step: cover property (@(posedge I_SYS_CLK) disable iff (I_SRST)
    !run_q && done);
  c_stop: cover property (@(posedge I_SYS_CLK) disable iff (I_SRST)
    run_q && stop_pend_q ##[1:20] !run_q);
  c_lamp: cover property (@(posedge I_SYS_CLK) disable iff (I_SRST)
    done && i_cyc_stat.output_cycle_flag && panel_hit);
  c_resume: cover property (@(posedge I_SYS_CLK) disable iff (I_SRST)
    !run_q ##1 run_q);
  c_in_port: cover property (@(posedge I_SYS_CLK) disable iff (I_SRST)
    o_port_sel);
endmodule

// File: sim/fpsc_cpu_model.sv
// Purpose: processor stand-in walking a fixed input, output and jump loop
// Assumes: each cycle is held until the panel raises ready
// Notes:   bus data not driven by memory shows a moving pattern
`timescale 1ns/1ps
module fpsc_cpu_model (
  input  wire logic           i_clk,
  input  wire logic           i_srst,
  input  wire logic           i_ready,
  input  wire logic [7:0]     i_port_data,
  input  wire logic [7:0]     i_out_port,
  output logic                o_valid,
  output fpsc_pkg::fpsc_cyc_t o_stat,
  output logic [15:0]         o_addr,
  output logic [7:0]          o_dout,
  output logic [7:0]          o_bus_data,
  output logic                o_wr_n,
  output logic [15:0]         o_ncomp
);
  logic [3:0]  idx_q;
  logic [7:0]  acc_q;
  logic [7:0]  noise_q;
  logic [27:0] cyc;
  // cycle table: status flags, address and memory byte of each step
  always_comb begin
    case (idx_q)
      4'h0:    cyc = {4'hC, 16'h0000, 8'hDB};
      4'h1:    cyc = {4'h8, 16'h0001, 8'hFF};
      4'h2:    cyc = {4'h2, 16'hFFFF, 8'h00};
      4'h3:    cyc = {4'hC, 16'h0002, 8'hD3};
      4'h4:    cyc = {4'h8, 16'h0003, 8'hFF};
      4'h6:    cyc = {4'hC, 16'h0004, 8'hC3};
      4'h7:    cyc = {4'h8, 16'h0005, 8'h00};
      4'h8:    cyc = {4'h8, 16'h0006, 8'h00};
      default: cyc = {4'h1, i_out_port, i_out_port, 8'h00};
    endcase
  end
  // outputs; data lines not owned this cycle never repeat the last value
  assign o_stat     = fpsc_pkg::fpsc_cyc_t'(cyc[27:24]);
  assign o_addr     = cyc[23:8];
  assign o_bus_data = cyc[27] ? cyc[7:0] : noise_q;
  assign o_wr_n     = (idx_q != 4'h5);
  assign o_dout     = o_wr_n ? noise_q : acc_q;
  // cycle sequencing: advance only when the panel completes the cycle
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      idx_q   <= 4'h0;
      o_ncomp <= 16'h0000;
      o_valid <= 1'b0;
    end else begin
      o_valid <= 1'b1;
      if (o_valid && i_ready) begin
        idx_q   <= (idx_q == 4'h8) ? 4'h0 : idx_q + 4'h1;
        o_ncomp <= o_ncomp + 16'h0001;
      end
    end
  end
  // accumulator loads from the switch port at the end of the input cycle;
  // the panel select comes a clock late, so a free-running input cycle ends
  // before it, while the registered switch byte already stands
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      acc_q   <= 8'h00;
      noise_q <= 8'h00;
    end else begin
      noise_q <= noise_q + 8'h3B;
      if (o_valid && i_ready && idx_q == 4'h2 && o_addr[7:0] == fpsc_pkg::PANEL_PORT)
        acc_q <= i_port_data;
    end
  end
endmodule

// File: sim/front_panel_step_control_tb_top.sv
// Purpose: self-checking bench for the front panel step control block
// Assumes: debounce shortened to four cycles
// Notes:   processor side comes from fpsc_cpu_model
`timescale 1ns/1ps
module front_panel_step_control_tb_top;
  logic                 sys_clk = 1'b0;
  logic                 srst = 1'b1;
  logic                 i_cyc_valid, i_cpu_wr_n, o_cpu_ready, o_port_sel;
  logic                 o_run_lamp, o_wait_lamp, pready, pslverr, err;
  fpsc_pkg::fpsc_cyc_t  i_cyc_stat;
  fpsc_pkg::fpsc_lamp_t o_stat_lamp;
  logic [15:0]          i_cpu_addr, o_addr_lamp, ncomp, n0;
  logic [7:0]           i_cpu_dout, i_bus_data, o_port_data, o_data_lamp, o_prog_lamp;
  logic [7:0]           i_data_sw = 8'hA5;
  logic [7:0]           out_port = 8'hFF;
  logic [3:0]           sws = 4'h0;
  logic                 psel = 1'b0;
  logic                 penable = 1'b0;
  logic                 pwrite = 1'b0;
  logic [7:0]           paddr = 8'h00;
  logic [31:0]          pwdata = 32'h0;
  logic [31:0]          prdata, rd;
  logic [36:0]          rows [10];
  logic [36:0]          r;
  int                   errors = 0;
  int                   n_checks = 0;
  // 50 MHz clock
  always #10 sys_clk = ~sys_clk;
  fpsc_top #(.DEB_CYC(4)) dut (
    .I_SYS_CLK(sys_clk), .I_SRST(srst), .i_cyc_valid, .i_cyc_stat, .i_cpu_addr,
    .i_cpu_dout, .i_bus_data, .i_cpu_wr_n, .o_cpu_ready, .o_port_data, .o_port_sel,
    .i_run_sw(sws[2]), .i_stop_sw(sws[3]), .i_step_up_sw(sws[0]), .i_step_dn_sw(sws[1]),
    .i_data_sw, .o_addr_lamp, .o_data_lamp, .o_stat_lamp, .o_prog_lamp, .o_run_lamp,
    .o_wait_lamp, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr
  );
  fpsc_cpu_model cpu (
    .i_clk(sys_clk), .i_srst(srst), .i_ready(o_cpu_ready), .i_port_data(o_port_data),
    .i_out_port(out_port), .o_valid(i_cyc_valid),
    .o_stat(i_cyc_stat), .o_addr(i_cpu_addr), .o_dout(i_cpu_dout),
    .o_bus_data(i_bus_data), .o_wr_n(i_cpu_wr_n), .o_ncomp(ncomp)
  );
  // compare and count
  task automatic check(input logic [36:0] seen, input logic [36:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // one apb transfer, request held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rdat, output logic erv);
    int n;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n == 50) errors++;
    rdat = prdata;
    erv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // hold one switch closed long enough to settle, then open it
  task automatic press(input int b);
    sws[b] <= 1'b1;
    repeat (10) @(posedge sys_clk);
    sws <= 4'h0;
    repeat (20) @(posedge sys_clk);
  endtask
  // single step by lever up, lever down or control register
  task automatic step(input int kind);
    logic [15:0] c0;
    c0 = ncomp;
    if (kind == 2) apb(1'b1, fpsc_pkg::REG_CTRL, 32'h1 << fpsc_pkg::CTRL_STEP, rd, err);
    else press(kind);
    repeat (10) @(posedge sys_clk);
    check(ncomp, c0 + 16'h0001);
  endtask
  // lamp row: address, status, data, programmed output
  task automatic look(input int k);
    r = rows[k];
    check(o_addr_lamp, r[36:21]);
    check(o_stat_lamp, r[20:16]);
    check(o_data_lamp, r[15:8]);
    check(o_prog_lamp, r[7:0]);
    check(o_port_sel, k == 2);
    check(o_wait_lamp, 1'b1);
  endtask
  // main sequence
  initial begin
    rows = '{{16'h0000, 5'h19, 8'hDB, 8'h00}, {16'h0001, 5'h11, 8'hFF, 8'h00},
             {16'hFFFF, 5'h05, 8'hA5, 8'h00}, {16'h0002, 5'h19, 8'hD3, 8'h00},
             {16'h0003, 5'h11, 8'hFF, 8'h00}, {16'hFFFF, 5'h02, 8'hA5, 8'h00},
             {16'h0004, 5'h19, 8'hC3, 8'h5A}, {16'h0005, 5'h11, 8'h00, 8'h5A},
             {16'h0006, 5'h11, 8'h00, 8'h5A}, {16'h0000, 5'h19, 8'hDB, 8'h5A}};
    repeat (8) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    check(o_prog_lamp, fpsc_pkg::PROG_LAMP_RST);
    check(o_run_lamp, fpsc_pkg::RUN_RST);
    repeat (3) @(posedge sys_clk);
    look(0);
    for (int i = 1; i < 10; i++) begin
      step(i % 3);
      look(i);
    end
    // contact bounce shorter than the settle time must not step
    n0 = ncomp;
    repeat (3) begin
      sws[0] <= 1'b1;
      repeat (2) @(posedge sys_clk);
      sws[0] <= 1'b0;
      repeat (2) @(posedge sys_clk);
    end
    repeat (30) @(posedge sys_clk);
    check(ncomp, n0);
    step(1);
    // register reads: lamp latch and an unmapped address
    apb(1'b0, fpsc_pkg::REG_LAMP, 32'h0, rd, err);
    check({err, rd}, {1'b0, 32'h0000A55A});
    apb(1'b0, 8'h40, 32'h0, rd, err);
    check(err, 1'b1);
    // run from the waiting cycle, then output to a foreign port
    n0 = ncomp;
    press(2);
    repeat (20) @(posedge sys_clk);
    check(o_run_lamp, 1'b1);
    check(ncomp > n0 + 16'h0014, 1'b1);
    out_port <= 8'h7F;
    i_data_sw <= 8'h3C;
    repeat (100) @(posedge sys_clk);
    check(o_prog_lamp, 8'h5A);
    out_port <= 8'hFF;
    repeat (100) @(posedge sys_clk);
    check(o_prog_lamp, 8'hC3);
    // stop while running halts on a fetch
    press(3);
    n0 = ncomp;
    repeat (20) @(posedge sys_clk);
    check(ncomp, n0);
    check(i_cyc_stat.opcode_fetch_flag, 1'b1);
    check(o_cpu_ready, 1'b0);
    apb(1'b0, fpsc_pkg::REG_STATUS, 32'h0, rd, err);
    check({err, rd}, {1'b0, 32'h1 << fpsc_pkg::ST_WAIT});
    // reset while stopped on a fetch clears the latch
    srst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    check(o_prog_lamp, fpsc_pkg::PROG_LAMP_RST);
    check(o_cpu_ready, 1'b0);
    srst <= 1'b0;
    repeat (3) @(posedge sys_clk);
    check(o_addr_lamp, 16'h0000);
    check(o_wait_lamp, 1'b1);
    print_verdict();
  end
  // watchdog
  initial begin
    repeat (10000) @(posedge sys_clk);
    errors++;
    print_verdict();
  end
endmodule
